/* rtl/pms_pkg.sv */
// Purpose: Shared constants, types and register map of the measurement sequencer.
// Assumes: A 20 MHz system clock and a 32-bit AXI4-Lite register bus.
// Notes: Every offset, the CTRL, OSR and STAT field positions, the settings reset value and the timing counts are named here once.
package pms_pkg;

  // System clock rate and the base sampling rate of the time base.
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned BASE_FREQ_HZ = 200;
  // Clock cycles in one base sampling period.
  localparam int unsigned BASE_TICK_CYCLES = CLK_FREQ_HZ / BASE_FREQ_HZ;
  // Largest rate select code; the prescaler is two to this power.
  localparam int unsigned ODR_MAX_DEF = 17;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OSR = 8'h04;
  localparam logic [7:0] REG_ODR = 8'h08;
  localparam logic [7:0] REG_FILT = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_PRESS = 8'h14;
  localparam logic [7:0] REG_TEMP = 8'h18;
  localparam logic [7:0] REG_CMD = 8'h1C;

  // Field positions.
  localparam int unsigned CTRL_PRESS_EN_BIT = 0;
  localparam int unsigned CTRL_TEMP_EN_BIT = 1;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned OSR_P_LSB = 0;
  localparam int unsigned OSR_T_LSB = 3;
  localparam int unsigned STAT_RDET_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_PEND_BIT = 2;
  localparam int unsigned STAT_MODE_LSB = 4;

  // Highest legal oversampling code, the soft reset code and bus responses.
  localparam logic [2:0] OSR_MAX = 3'h5;
  localparam logic [7:0] SOFT_RESET_CODE = 8'hA5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power modes as kept in the mode state.
  typedef enum logic [1:0] {
    MD_SLEEP = 2'b00,
    MD_FORCED = 2'b01,
    MD_NORMAL = 2'b11
  } pms_mode_e;

  // Steps of one measurement period.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TEMP = 2'b01,
    ST_PRESS = 2'b10
  } pms_meas_e;

  // Channel enables and measurement settings written by software.
  typedef struct packed {
    logic temp_en;
    logic press_en;
    logic [2:0] osr_t;
    logic [2:0] osr_p;
    logic [4:0] odr;
    logic [6:0] coef;
  } pms_cfg_s;

  // Settings after any reset.
  localparam pms_cfg_s CFG_RESET = '0;

endpackage

/* rtl/pms_core.sv */
// Purpose: Measurement sequencer of a pressure and temperature sensor with an AXI4-Lite register file.
// Assumes: Converter results arrive on conv_done with conv_data right-aligned to the selected resolution.
// Notes: Filtering is applied to each channel result as it arrives; the divide is combinational.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pms_core #(
  parameter int unsigned BASE_TICKS = pms_pkg::BASE_TICK_CYCLES,
  parameter int unsigned ODR_MAX = pms_pkg::ODR_MAX_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic conv_start,
  output logic conv_temp,
  output logic [2:0] conv_osr,
  input wire logic conv_done,
  input wire logic [20:0] conv_data
);

  // Refuse sizes that the counters cannot hold.
  if (BASE_TICKS < 2 || BASE_TICKS > 24'hFFFFFF || ODR_MAX > 17) begin : g_bad_param
    $error("pms_core: BASE_TICKS or ODR_MAX out of range");
  end

  // Bus state: held address and data, and the pending responses.
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic w_lane0, next_w_lane0;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  // One-cycle strobes of an executed write and an accepted read.
  logic wr_fire, rd_fire;

  // Core state: settings, modes, counters, results and filter seeds.
  pms_pkg::pms_cfg_s cfg, next_cfg;
  pms_pkg::pms_mode_e mode_q, next_mode;
  pms_pkg::pms_mode_e pend_mode, next_pend_mode;
  pms_pkg::pms_meas_e meas_q, next_meas;
  logic pend_q, next_pend;
  logic rdet, next_rdet;
  logic srst, next_srst;
  logic [23:0] base_cnt, next_base_cnt;
  logic [17:0] presc_cnt, next_presc_cnt;
  logic [20:0] press_q, next_press, temp_q, next_temp;
  logic pvalid, next_pvalid, tvalid, next_tvalid;
  logic next_conv_start, next_conv_temp;
  logic [2:0] next_conv_osr;
  // Helper terms of the core step.
  logic tick, period_start, meas_end, busy, start_now, exec_valid;
  pms_pkg::pms_mode_e exec_mode, cmd_mode;

  // Clamps reserved oversampling codes to the largest legal one.
  // reserved codes clamp
  function automatic logic [2:0] osr_clamp(input logic [2:0] code);
    osr_clamp = (code > pms_pkg::OSR_MAX) ? pms_pkg::OSR_MAX : code;
  endfunction

  // Decodes the two-bit mode field.
  // mode field decode
  function automatic pms_pkg::pms_mode_e mode_decode(input logic [1:0] bits);
    if (bits == 2'b00)
    begin
      mode_decode = pms_pkg::MD_SLEEP;
    end
    else if (bits == 2'b11)
    begin
      mode_decode = pms_pkg::MD_NORMAL;
    end
    else
    begin
      mode_decode = pms_pkg::MD_FORCED;
    end
  endfunction

  // Only moves into or out of sleep are supported.
  function automatic logic mode_legal(input pms_pkg::pms_mode_e from, input pms_pkg::pms_mode_e to);
    mode_legal = (from != to) && (from == pms_pkg::MD_SLEEP || to == pms_pkg::MD_SLEEP);
  endfunction

  // Left-aligns a result so extra resolution bits land in the low bits.
  function automatic logic [20:0] align(input logic [20:0] raw, input logic [2:0] osr);
    align = 21'(raw << (pms_pkg::OSR_MAX - osr));
  endfunction

  // First-order filter; an unprimed filter or a zero coefficient passes the sample.
  function automatic logic [20:0] iir(input logic [20:0] old_v, input logic [20:0] new_v,
                                      input logic [6:0] c, input logic primed);
    logic [28:0] num;
    logic [28:0] den;
    num = 29'(old_v) * 29'(c) + 29'(new_v);
    den = 29'(c) + 29'h1;
    if (!primed || c == 7'h00)
    begin
      iir = new_v;
    end
    else
    begin
      iir = 21'(num / den);
    end
  endfunction

  // Bus step: collects address and data in either order, then answers.
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    wr_fire = aw_held && w_held && !s_axi_bvalid;
    rd_fire = s_axi_arvalid && s_axi_arready;
    // Capture each write channel when it is taken.
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    // Both halves present: the write executes and its response is raised.
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr > pms_pkg::REG_CMD || aw_addr[1:0] != 2'b00) ? pms_pkg::RESP_SLVERR
                                                                            : pms_pkg::RESP_OKAY;
    end
    // Read data is taken from the register map in the accepting cycle.
    // registers always readable
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rresp = pms_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        pms_pkg::REG_CTRL:
        begin
          next_rdata[pms_pkg::CTRL_PRESS_EN_BIT] = cfg.press_en;
          next_rdata[pms_pkg::CTRL_TEMP_EN_BIT] = cfg.temp_en;
          next_rdata[pms_pkg::CTRL_MODE_LSB +: 2] = mode_q;
        end
        pms_pkg::REG_OSR: next_rdata[5:0] = {cfg.osr_t, cfg.osr_p};
        pms_pkg::REG_ODR: next_rdata[4:0] = cfg.odr;
        pms_pkg::REG_FILT: next_rdata[6:0] = cfg.coef;
        pms_pkg::REG_STAT:
        begin
          next_rdata[pms_pkg::STAT_RDET_BIT] = rdet;
          next_rdata[pms_pkg::STAT_BUSY_BIT] = (meas_q != pms_pkg::ST_IDLE);
          next_rdata[pms_pkg::STAT_PEND_BIT] = pend_q;
          next_rdata[pms_pkg::STAT_MODE_LSB +: 2] = mode_q;
        end
        pms_pkg::REG_PRESS: next_rdata[23:0] = {press_q, 3'h0};
        pms_pkg::REG_TEMP: next_rdata[23:0] = {temp_q, 3'h0};
        pms_pkg::REG_CMD: next_rdata = 32'h0000_0000;
        default: next_rresp = pms_pkg::RESP_SLVERR;
      endcase
    end
    // Ready is offered only while the matching slot is free.
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // Bus registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pms_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= pms_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Core step: time base, conversion sequence, mode commands and filter seeds.
  always_comb
  begin
    next_cfg = cfg;
    next_mode = mode_q;
    next_pend = pend_q;
    next_pend_mode = pend_mode;
    next_meas = meas_q;
    next_rdet = rdet;
    next_srst = 1'b0;
    next_press = press_q;
    next_temp = temp_q;
    next_pvalid = pvalid;
    next_tvalid = tvalid;
    next_conv_start = 1'b0;
    next_conv_temp = conv_temp;
    next_conv_osr = conv_osr;
    next_base_cnt = 24'h000000;
    next_presc_cnt = 18'h00000;
    tick = 1'b0;
    period_start = 1'b0;
    meas_end = 1'b0;
    start_now = 1'b0;
    exec_valid = 1'b0;
    exec_mode = pms_pkg::MD_SLEEP;
    cmd_mode = mode_decode(w_data[pms_pkg::CTRL_MODE_LSB +: 2]);
    if (mode_q == pms_pkg::MD_NORMAL)
    begin
      tick = (base_cnt == 24'(BASE_TICKS - 1));
      next_base_cnt = tick ? 24'h000000 : base_cnt + 24'h000001;
      next_presc_cnt = presc_cnt;
      if (tick)
      begin
        period_start = (presc_cnt == (18'h00001 << cfg.odr) - 18'h00001);
        next_presc_cnt = period_start ? 18'h00000 : presc_cnt + 18'h00001;
      end
    end
    unique case (meas_q)
      pms_pkg::ST_IDLE:
      begin
      end
      pms_pkg::ST_TEMP:
      begin
        if (conv_done)
        begin
          next_temp = iir(temp_q, align(conv_data, conv_osr), cfg.coef, tvalid);
          next_tvalid = 1'b1;
          if (cfg.press_en)
          begin
            next_meas = pms_pkg::ST_PRESS;
            next_conv_start = 1'b1;
            next_conv_temp = 1'b0;
            next_conv_osr = osr_clamp(cfg.osr_p);
          end
          else
          begin
            meas_end = 1'b1;
          end
        end
      end
      pms_pkg::ST_PRESS:
      begin
        if (conv_done)
        begin
          next_press = iir(press_q, align(conv_data, conv_osr), cfg.coef, pvalid);
          next_pvalid = 1'b1;
          meas_end = 1'b1;
        end
      end
      default: next_meas = pms_pkg::ST_IDLE;
    endcase
    if (meas_end)
    begin
      next_meas = pms_pkg::ST_IDLE;
      if (mode_q == pms_pkg::MD_FORCED)
      begin
        next_mode = pms_pkg::MD_SLEEP;
      end
    end
    busy = (meas_q != pms_pkg::ST_IDLE) && !meas_end;
    if (pend_q && !busy)
    begin
      next_pend = 1'b0;
      exec_valid = 1'b1;
      exec_mode = pend_mode;
    end
    // Register writes; only the low byte lane carries fields.
    if (wr_fire && w_lane0)
    begin
      unique case (aw_addr)
        pms_pkg::REG_CTRL:
        begin
          next_cfg.press_en = w_data[pms_pkg::CTRL_PRESS_EN_BIT];
          next_cfg.temp_en = w_data[pms_pkg::CTRL_TEMP_EN_BIT];
          if (!pend_q && mode_legal(mode_q, cmd_mode))
          begin
            if (busy)
            begin
              next_pend = 1'b1;
              next_pend_mode = cmd_mode;
            end
            else
            begin
              exec_valid = 1'b1;
              exec_mode = cmd_mode;
            end
          end
        end
        pms_pkg::REG_OSR:
        begin
          next_cfg.osr_p = w_data[pms_pkg::OSR_P_LSB +: 3];
          next_cfg.osr_t = w_data[pms_pkg::OSR_T_LSB +: 3];
        end
        pms_pkg::REG_ODR: next_cfg.odr = (w_data[4:0] > 5'(ODR_MAX)) ? 5'(ODR_MAX) : w_data[4:0];
        pms_pkg::REG_FILT:
        begin
          next_cfg.coef = w_data[6:0];
          next_pvalid = 1'b0;
          next_tvalid = 1'b0;
        end
        pms_pkg::REG_CMD: next_srst = (w_data[7:0] == pms_pkg::SOFT_RESET_CODE);
        default:
        begin
        end
      endcase
    end
    if (next_cfg.press_en != cfg.press_en)
    begin
      next_pvalid = 1'b0;
    end
    if (next_cfg.temp_en != cfg.temp_en)
    begin
      next_tvalid = 1'b0;
    end
    if (exec_valid && mode_legal(next_mode, exec_mode))
    begin
      start_now = (exec_mode != pms_pkg::MD_SLEEP);
      if (exec_mode == pms_pkg::MD_NORMAL)
      begin
        next_pvalid = 1'b0;
        next_tvalid = 1'b0;
        next_base_cnt = 24'h000000;
        next_presc_cnt = 18'h00000;
      end
      next_mode = exec_mode;
    end
    if ((start_now || (next_mode == pms_pkg::MD_NORMAL && period_start)) && next_meas == pms_pkg::ST_IDLE)
    begin
      if (next_cfg.temp_en)
      begin
        next_meas = pms_pkg::ST_TEMP;
        next_conv_start = 1'b1;
        next_conv_temp = 1'b1;
        next_conv_osr = osr_clamp(next_cfg.osr_t);
      end
      else if (next_cfg.press_en)
      begin
        next_meas = pms_pkg::ST_PRESS;
        next_conv_start = 1'b1;
        next_conv_temp = 1'b0;
        next_conv_osr = osr_clamp(next_cfg.osr_p);
      end
      else if (next_mode == pms_pkg::MD_FORCED)
      begin
        next_mode = pms_pkg::MD_SLEEP;
      end
    end
    if (rd_fire && s_axi_araddr == pms_pkg::REG_STAT)
    begin
      next_rdet = 1'b0;
    end
    if (srst)
    begin
      next_cfg = pms_pkg::CFG_RESET;
      next_mode = pms_pkg::MD_SLEEP;
      next_meas = pms_pkg::ST_IDLE;
      next_pend = 1'b0;
      next_pvalid = 1'b0;
      next_tvalid = 1'b0;
      next_press = 21'h000000;
      next_temp = 21'h000000;
      next_conv_start = 1'b0;
      next_rdet = 1'b1;
    end
  end

  // Core registers; power-on reset leaves sleep with the flag raised.
  // reset enters sleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg <= pms_pkg::CFG_RESET;
      mode_q <= pms_pkg::MD_SLEEP;
      pend_mode <= pms_pkg::MD_SLEEP;
      meas_q <= pms_pkg::ST_IDLE;
      pend_q <= 1'b0;
      rdet <= 1'b1;
      srst <= 1'b0;
      base_cnt <= 24'h000000;
      presc_cnt <= 18'h00000;
      press_q <= 21'h000000;
      temp_q <= 21'h000000;
      pvalid <= 1'b0;
      tvalid <= 1'b0;
      conv_start <= 1'b0;
      conv_temp <= 1'b0;
      conv_osr <= 3'h0;
    end
    else
    begin
      cfg <= next_cfg;
      mode_q <= next_mode;
      pend_mode <= next_pend_mode;
      meas_q <= next_meas;
      pend_q <= next_pend;
      rdet <= next_rdet;
      srst <= next_srst;
      base_cnt <= next_base_cnt;
      presc_cnt <= next_presc_cnt;
      press_q <= next_press;
      temp_q <= next_temp;
      pvalid <= next_pvalid;
      tvalid <= next_tvalid;
      conv_start <= next_conv_start;
      conv_temp <= next_conv_temp;
      conv_osr <= next_conv_osr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Settling sequence after a power-on reset.
  sequence s_settled;
    mode_q == pms_pkg::MD_SLEEP && rdet && meas_q == pms_pkg::ST_IDLE;
  endsequence

  AST_RESET_SLEEP: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> s_settled)
    else $error("reset did not settle in sleep");
  AST_SLEEP_NO_CONV: assert property (conv_start |-> mode_q != pms_pkg::MD_SLEEP)
    else $error("conversion started in sleep");
  AST_RDET_CLEAR: assert property (rd_fire && s_axi_araddr == pms_pkg::REG_STAT && !srst |=> !rdet)
    else $error("reset flag not cleared by read");
  AST_FORCED_SLEEP: assert property (mode_q == pms_pkg::MD_FORCED && meas_end |=> mode_q == pms_pkg::MD_SLEEP)
    else $error("forced mode did not return to sleep");
  AST_DEFER: assert property (busy && !srst |=> mode_q == $past(mode_q))
    else $error("mode changed during measurement");
  AST_PEND_HOLD: assert property (pend_q && busy && !srst |=> pend_q && pend_mode == $past(pend_mode))
    else $error("pending mode command was replaced");
  AST_NO_ILLEGAL: assert property (mode_q == pms_pkg::MD_NORMAL |=> mode_q != pms_pkg::MD_FORCED)
    else $error("unsupported mode transition taken");
  AST_PRESS_GATE: assert property (conv_start && !conv_temp |-> cfg.press_en)
    else $error("pressure converted while disabled");
  AST_TEMP_GATE: assert property (conv_start && conv_temp |-> cfg.temp_en)
    else $error("temperature converted while disabled");
  AST_OSR_CLAMP: assert property (conv_start |-> conv_osr <= pms_pkg::OSR_MAX)
    else $error("oversampling code above limit");
  AST_FILT_RESET: assert property (wr_fire && w_lane0 && aw_addr == pms_pkg::REG_FILT |=> !pvalid && !tvalid)
    else $error("filter not reset by configuration write");

endmodule

`default_nettype wire

/* testbench/pms_conv_model.sv */
// Purpose: Converter stand-in facing the sequencer's conversion port.
// Assumes: At most one conversion is outstanding at a time.
// Notes: The data lines toggle whenever no result is offered.
`timescale 1ns/1ps
`default_nettype none
module pms_conv_model (
  input wire logic aclk,
  input wire logic conv_start,
  input wire logic conv_temp,
  input wire logic slow,
  input wire logic [20:0] pval,
  input wire logic [20:0] tval,
  output logic conv_done,
  output logic [20:0] conv_data,
  output int starts,
  output int gap
);
  // Cycles left in the running conversion, and a free-running cycle count.
  int cnt = 0;
  int cyc = 0;
  int last = 0;
  logic tsel = 1'b0;
  // Output copies, so that each output has exactly one driver.
  logic done_q = 1'b0;
  logic [20:0] data_q = '0;
  int starts_q = 0;
  int gap_q = 0;
  assign conv_done = done_q;
  assign conv_data = data_q;
  assign starts = starts_q;
  assign gap = gap_q;
  // Answers after 3 cycles, or 40 when slow; the result stands one cycle.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    done_q <= (cnt == 1);
    data_q <= (cnt == 1) ? (tsel ? tval : pval) : ~data_q;
    if (cnt > 0)
      cnt <= cnt - 1;
    if (conv_start)
    begin
      cnt <= slow ? 40 : 3;
      tsel <= conv_temp;
      starts_q <= starts_q + 1;
    end
    if (conv_start && conv_temp)
    begin
      gap_q <= cyc - last;
      last <= cyc;
    end
  end
endmodule
`default_nettype wire

/* testbench/pressure_measurement_sequencer_bench.sv */
// Purpose: Self-checking bench of the measurement sequencer.
// Assumes: BASE_TICKS of 20 keeps normal-mode periods short.
// Notes: All register traffic goes through the AXI4-Lite tasks.
`timescale 1ns/1ps
`default_nettype none
module pressure_measurement_sequencer_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cst, ctmp, cdone;
  logic [1:0] bresp, rresp, r;
  logic [3:0] strb = 4'hF;
  logic [20:0] cdata, pval = 21'h5678, tval = 21'h1234;
  int starts, gap, s0, failures = 0, samples_checked = 0;
  always #25 aclk = ~aclk;
  pms_core #(.BASE_TICKS(20)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_start(cst), .conv_temp(ctmp), .conv_osr(), .conv_done(cdone), .conv_data(cdata));
  pms_conv_model MDL (.aclk(aclk), .conv_start(cst), .conv_temp(ctmp), .slow(slow), .pval(pval),
    .tval(tval), .conv_done(cdone), .conv_data(cdata), .starts(starts), .gap(gap));
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write: both channels offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Read: data and response land in v and r.
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Polls status until idle in sleep with nothing pending.
  task automatic idle;
    do
      rd(pms_pkg::REG_STAT);
    while (v[5:1] !== 5'h0);
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pms_pkg::REG_STAT);
    chk(v, 32'h1);
    rd(pms_pkg::REG_STAT);
    chk(v, 32'h0);
    rd(8'h20);
    chk(32'(r), 32'(pms_pkg::RESP_SLVERR));
    for (int i = 0; i < 8; i++)
    begin
      wr(pms_pkg::REG_OSR, 32'(i * 9));
      wr(pms_pkg::REG_CTRL, i[0] ? 32'h13 : 32'h23);
      idle;
      rd(pms_pkg::REG_TEMP);
      chk(v, 32'(tval) << (8 - (i > 5 ? 5 : i)));
      rd(pms_pkg::REG_PRESS);
      chk(v, 32'(pval) << (8 - (i > 5 ? 5 : i)));
    end
    rd(pms_pkg::REG_OSR);
    chk(v, 32'h3F);
    for (int j = 0; j < 3; j++)
    begin
      s0 = starts;
      wr(pms_pkg::REG_CTRL, j == 0 ? 32'h11 : (j == 1 ? 32'h22 : 32'h10));
      idle;
      chk(32'(starts - s0), j < 2 ? 32'h1 : 32'h0);
    end
    s0 = starts;
    repeat (100) @(posedge aclk);
    chk(32'(starts - s0), 32'h0);
    wr(pms_pkg::REG_OSR, 32'h0D);
    wr(pms_pkg::REG_FILT, 32'h1);
    wr(pms_pkg::REG_CTRL, 32'h13);
    idle;
    rd(pms_pkg::REG_TEMP);
    chk(v, 32'h1234 << 7);
    tval <= 21'h2234;
    wr(pms_pkg::REG_CTRL, 32'h13);
    idle;
    rd(pms_pkg::REG_TEMP);
    chk(v, 32'h1A34 << 7);
    wr(pms_pkg::REG_FILT, 32'h1);
    wr(pms_pkg::REG_CTRL, 32'h13);
    idle;
    rd(pms_pkg::REG_TEMP);
    chk(v, 32'h2234 << 7);
    wr(pms_pkg::REG_ODR, 32'h1);
    wr(pms_pkg::REG_CTRL, 32'h33);
    repeat (150) @(posedge aclk);
    chk(32'(gap), 32'd40);
    wr(pms_pkg::REG_CTRL, 32'h13);
    rd(pms_pkg::REG_CTRL);
    chk(v, 32'h33);
    wr(pms_pkg::REG_CTRL, 32'h03);
    idle;
    slow <= 1'b1;
    s0 = starts;
    wr(pms_pkg::REG_CTRL, 32'h33);
    wr(pms_pkg::REG_CTRL, 32'h03);
    rd(pms_pkg::REG_STAT);
    chk(v, 32'h36);
    wr(pms_pkg::REG_CTRL, 32'h13);
    idle;
    rd(pms_pkg::REG_CTRL);
    chk(v, 32'h03);
    chk(32'(starts - s0), 32'h2);
    slow <= 1'b0;
    wr(pms_pkg::REG_CMD, 32'hA5);
    rd(pms_pkg::REG_STAT);
    chk(v, 32'h1);
    rd(pms_pkg::REG_CTRL);
    chk(v, 32'h0);
    // Unmapped write is refused; a write without the low lane changes nothing.
    wr(8'h20, 32'h0);
    chk(32'(r), 32'(pms_pkg::RESP_SLVERR));
    strb <= 4'h0;
    wr(pms_pkg::REG_FILT, 32'h7F);
    strb <= 4'hF;
    chk(32'(r), 32'(pms_pkg::RESP_OKAY));
    rd(pms_pkg::REG_FILT);
    chk(v, 32'h0);
    end_of_test;
  end
  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_of_test;
  end
endmodule
`default_nettype wire
